// [src/npiu_defs.vh]
// Constants shared by the nested priority interrupt unit.
// Included by bare name from every module of the unit.
`ifndef NPIU_DEFS_VH
`define NPIU_DEFS_VH

// Stack pointer: reset value, movable low part, reload value
`define NPIU_SP_RESET     16'h017F
`define NPIU_SP_LOW_W     7
`define NPIU_SP_RELOAD    7'h7F

// Fixed vector addresses
`define NPIU_VEC_RESET    16'hFFFE
`define NPIU_VEC_TRAP     16'hFFFC
`define NPIU_VEC_TOP      16'hFFFA
`define NPIU_VEC_LOWEST   16'hFFE0
`define NPIU_NUM_VEC      14

// Priority codes as held in flag bits 5 and 3
`define NPIU_CODE_L0      2'h2
`define NPIU_CODE_L1      2'h1
`define NPIU_CODE_L2      2'h0
`define NPIU_CODE_L3      2'h3
`define NPIU_CC_BIT_HI    5
`define NPIU_CC_BIT_LO    3

// Per-vector priority bank
`define NPIU_PRIO_RESET   8'hFF
`define NPIU_PRIO3_RO     8'hF0

// Stack frame sizes in bytes
`define NPIU_INT_FRAME    3'h5
`define NPIU_CALL_FRAME   3'h2

`endif

// [src/npiu_stack_ptr.v]
// Stack pointer of the unit: 16-bit value, only the low 7 bits move.
// Assumes at most one of inc/dec per source; simultaneous inc and dec cancel.
`timescale 1ns/100ps
`default_nettype none
`include "npiu_defs.vh"

module npiu_stack_ptr (
    input  wire        clock_i,
    input  wire        rst_b_i,
    input  wire        reinit_i,
    input  wire        load_i,
    input  wire [7:0]  load_data_i,
    input  wire        dec_i,
    input  wire        inc_i,
    output wire [15:0] sp_o
);
    localparam [15:0] SP_RST = `NPIU_SP_RESET;

    reg [`NPIU_SP_LOW_W-1:0] low_r;

    // Upper nine bits are fixed, so the 7-bit counter wraps silently
    assign sp_o = {SP_RST[15:7], low_r};

    // Reset and reinit load the top of stack; decrement after push, increment before pop
    always @(posedge clock_i) begin
        if (!rst_b_i || reinit_i) begin
            low_r <= `NPIU_SP_RELOAD;
        end else if (load_i) begin
            low_r <= load_data_i[6:0];
        end else if (dec_i && !inc_i) begin
            low_r <= low_r - 7'h01;
        end else if (inc_i && !dec_i) begin
            low_r <= low_r + 7'h01;
        end
    end
endmodule // npiu_stack_ptr

`default_nettype wire

// [src/npiu_arbiter.v]
// Two-step arbiter for the maskable vectors 1..13 (index 0 is the top pin).
// Purely combinational; pending and enables come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "npiu_defs.vh"

module npiu_arbiter #(
    parameter NV = `NPIU_NUM_VEC
) (
    input  wire [NV-1:0]   pend_i,
    input  wire [NV-1:0]   en_i,
    input  wire [2*NV-1:0] prio_i,
    input  wire [1:0]      cur_code_i,
    output reg             win_o,
    output reg  [3:0]      win_idx_o,
    output reg  [1:0]      win_code_o
);
    // Code to numeric level 0..3
    function [1:0] code_to_lvl;
        input [1:0] code;
        begin
            case (code)
                `NPIU_CODE_L0: code_to_lvl = 2'h0;
                `NPIU_CODE_L1: code_to_lvl = 2'h1;
                `NPIU_CODE_L2: code_to_lvl = 2'h2;
                default:       code_to_lvl = 2'h3;
            endcase
        end
    endfunction

    integer i;
    reg [1:0] lvl;
    reg [1:0] best;

    // Walk from lowest to highest hardware priority; ties go to later ones
    always @* begin
        win_o      = 1'b0;
        win_idx_o  = 4'h0;
        win_code_o = `NPIU_CODE_L3;
        best       = 2'h0;
        lvl        = 2'h0;
        for (i = NV - 1; i >= 1; i = i - 1) begin
            lvl = code_to_lvl(prio_i[2*i +: 2]);
            if (pend_i[i] && en_i[i] && lvl > code_to_lvl(cur_code_i)) begin
                if (!win_o || lvl >= best) begin
                    win_o      = 1'b1;
                    best       = lvl;
                    win_idx_o  = i[3:0];
                    win_code_o = prio_i[2*i +: 2];
                end
            end
        end
    end
endmodule // npiu_arbiter

`default_nettype wire

// [src/npiu_core.v]
// Nested priority interrupt unit: priority flags, vector priority bank,
// arbitration, context stacking and return. Sits beside the CPU sequencer.
// Assumes stack RAM read data is valid one cycle after the address.
`timescale 1ns/100ps
`default_nettype none
`include "npiu_defs.vh"

// Function
// - Flag bits 5,3 code level 0=10, 1=01, 2=00, 3=11 (masked).
// - Entering a handler loads the flag bits from that vector's priority.
// - Unmask, mask, return, halt, wait and pop may write the flag bits.
// - 16-bit stack pointer points to next free byte; resets to 017Fh.
// - Upper nine bits fixed; reset or reinit sets the lower seven.
// - Stack pointer wraps silently on overflow and underflow.
// - Call uses two bytes, interrupt five; program counter low written first.
// - Service after the instruction: push context, set level, load vector.
// - Return pops the context including the two flag bits.
// - Sixteen fixed vectors from FFE0h to FFFFh by hardware priority.
// - After reset the program counter loads from the vector at FFFEh.
// - Highest software level wins; ties go to highest hardware priority.
// - Unserved requests stay latched until they become highest.
// - Reset, trap and top pin count as highest software level.
// - Non-maskable sources ignore the level, stack context, set level 3.
// - Every non-maskable source ends halt mode.
// - Four programmable nesting levels of priority.
// - Maskable request taken only if enabled and above current level.
// - Writing the level-0 code into a vector field keeps the old value.
// - Hardware priority: main, vectors low to high, then the top pin.
module npiu_core #(
    parameter NV            = `NPIU_NUM_VEC,
    parameter HALT_WAKE_MSK = 14'h3FFF
) (
    input  wire            clock_i,
    input  wire            rst_b_i,
    input  wire            instr_end_i,
    input  wire            unmask_instr_i,
    input  wire            mask_all_instr_i,
    input  wire            return_from_handler_i,
    input  wire            halt_instr_i,
    input  wire            wait_for_irq_instr_i,
    input  wire            cc_pop_i,
    input  wire [7:0]      cc_pop_data_i,
    input  wire            trap_instr_i,
    input  wire            stack_reinit_instr_i,
    input  wire            sp_load_i,
    input  wire [7:0]      sp_load_data_i,
    input  wire            cpu_push_i,
    input  wire            cpu_pop_i,
    input  wire [15:0]     pc_i,
    input  wire [7:0]      x_i,
    input  wire [7:0]      a_i,
    input  wire [7:0]      cc_i,
    input  wire            top_pin_irq_i,
    input  wire [NV-1:0]   irq_req_i,
    input  wire [NV-1:0]   irq_en_i,
    input  wire            prio_wr_i,
    input  wire [1:0]      prio_addr_i,
    input  wire [7:0]      prio_wdata_i,
    output reg  [7:0]      prio_rdata_o,
    input  wire [7:0]      ram_rdata_i,
    output wire [15:0]     ram_addr_o,
    output reg  [7:0]      ram_wdata_o,
    output wire            ram_we_o,
    output wire [15:0]     stack_ptr_o,
    output wire [1:0]      flags_prio_o,
    output reg             vec_load_o,
    output reg  [15:0]     vec_addr_o,
    output reg             restore_o,
    output reg  [15:0]     pc_o,
    output reg  [7:0]      x_o,
    output reg  [7:0]      a_o,
    output reg  [7:0]      cc_o,
    output reg  [NV-1:0]   irq_ack_o,
    output wire            busy_o,
    output wire            halted_o
);
    localparam [2:0] S_RSTV = 3'h0;
    localparam [2:0] S_IDLE = 3'h1;
    localparam [2:0] S_PUSH = 3'h2;
    localparam [2:0] S_VEC  = 3'h3;
    localparam [2:0] S_POPA = 3'h4;
    localparam [2:0] S_POPD = 3'h5;
    localparam [15:0] VEC_TOP = `NPIU_VEC_TOP;

    reg [2:0]      state_r;
    reg [2:0]      cnt_r;
    reg [1:0]      cur_code_r;
    reg [31:0]     prio_r;
    reg [NV-1:0]   pend_r;
    reg            tli_s1_r;
    reg            tli_s2_r;
    reg            tli_s3_r;
    reg            tli_pend_r;
    reg            trap_pend_r;
    reg            halt_r;
    reg            wait_r;
    reg [15:0]     sel_vec_r;
    reg [1:0]      sel_code_r;
    reg [NV-1:0]   sel_ack_r;
    reg [7:0]      cc_push_r;

    wire           win;
    wire [3:0]     win_idx;
    wire [1:0]     win_code;
    wire           sp_dec;
    wire           sp_inc;
    wire           nmi_any;
    wire           wake;
    wire           boundary;
    wire           take;

    // Merge a bank write field by field, skipping level-0 codes
    function [7:0] field_merge;
        input [7:0] old_v;
        input [7:0] new_v;
        integer k;
        begin
            field_merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (new_v[2*k +: 2] != `NPIU_CODE_L0) begin
                    field_merge[2*k +: 2] = new_v[2*k +: 2];
                end
            end
        end
    endfunction

    npiu_stack_ptr u_sp (
        .clock_i     (clock_i),
        .rst_b_i     (rst_b_i),
        .reinit_i    (stack_reinit_instr_i),
        .load_i      (sp_load_i),
        .load_data_i (sp_load_data_i),
        .dec_i       (sp_dec),
        .inc_i       (sp_inc),
        .sp_o        (stack_ptr_o)
    );

    npiu_arbiter #(.NV(NV)) u_arb (
        .pend_i      (pend_r),
        .en_i        (irq_en_i),
        .prio_i      (prio_r[2*NV-1:0]),
        .cur_code_i  (cur_code_r),
        .win_o       (win),
        .win_idx_o   (win_idx),
        .win_code_o  (win_code)
    );

    // CPU calls move the pointer by two single-byte pushes of its own
    assign sp_dec = (state_r == S_PUSH) | cpu_push_i;
    assign sp_inc = (state_r == S_POPA) | cpu_pop_i;
    // Pop reads one above the pointer, wrapping inside the stack page
    assign ram_addr_o = (state_r == S_POPA) ? {stack_ptr_o[15:7], stack_ptr_o[6:0] + 7'h01}
                                            : stack_ptr_o;
    assign ram_we_o   = (state_r == S_PUSH);
    assign busy_o     = (state_r != S_IDLE);
    assign halted_o   = halt_r;
    assign flags_prio_o = cur_code_r;

    // Halt wakes only on non-maskable or halt-capable sources; wait on any
    assign nmi_any  = tli_pend_r | trap_pend_r;
    assign wake     = halt_r ? (nmi_any | (win & HALT_WAKE_MSK[win_idx]))
                             : (nmi_any | win);
    assign boundary = instr_end_i | ((halt_r | wait_r) & wake);
    assign take     = boundary & (nmi_any | win) & !return_from_handler_i;

    // Top pin passes two flops before the edge detector reads it
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            tli_s1_r <= 1'b0;
            tli_s2_r <= 1'b0;
            tli_s3_r <= 1'b0;
        end else begin
            tli_s1_r <= top_pin_irq_i;
            tli_s2_r <= tli_s1_r;
            tli_s3_r <= tli_s2_r;
        end
    end

    // Request latches; a new request in the clear cycle is kept
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            pend_r      <= {NV{1'b0}};
            tli_pend_r  <= 1'b0;
            trap_pend_r <= 1'b0;
        end else begin
            pend_r <= (pend_r & ~((state_r == S_IDLE && take && !nmi_any)
                                  ? sel_onehot(win_idx) : {NV{1'b0}}))
                      | irq_req_i;
            if (tli_s2_r && !tli_s3_r) begin
                tli_pend_r <= 1'b1;
            end else if (state_r == S_IDLE && take && tli_pend_r) begin
                tli_pend_r <= 1'b0;
            end
            if (trap_instr_i) begin
                trap_pend_r <= 1'b1;
            end else if (state_r == S_IDLE && take && !tli_pend_r) begin
                trap_pend_r <= 1'b0;
            end
        end
    end

    // One-hot of a vector index
    function [NV-1:0] sel_onehot;
        input [3:0] idx;
        begin
            sel_onehot = {NV{1'b0}};
            sel_onehot[idx] = 1'b1;
        end
    endfunction

    // Vector priority bank; top nibble of the last register stays ones
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            prio_r       <= {4{`NPIU_PRIO_RESET}};
            prio_rdata_o <= 8'h00;
        end else begin
            if (prio_wr_i) begin
                prio_r[8*prio_addr_i +: 8] <=
                    field_merge(prio_r[8*prio_addr_i +: 8], prio_wdata_i)
                    | ((prio_addr_i == 2'h3) ? `NPIU_PRIO3_RO : 8'h00);
            end
            prio_rdata_o <= prio_r[8*prio_addr_i +: 8];
        end
    end

    // Sequencer: reset vector, context push, vector load, context pop
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            state_r    <= S_RSTV;
            cnt_r      <= 3'h0;
            cur_code_r <= `NPIU_CODE_L3;
            halt_r     <= 1'b0;
            wait_r     <= 1'b0;
            sel_vec_r  <= `NPIU_VEC_RESET;
            sel_code_r <= `NPIU_CODE_L3;
            sel_ack_r  <= {NV{1'b0}};
            cc_push_r  <= 8'h00;
            vec_load_o <= 1'b0;
            vec_addr_o <= 16'h0000;
            restore_o  <= 1'b0;
            irq_ack_o  <= {NV{1'b0}};
            ram_wdata_o <= 8'h00;
            pc_o <= 16'h0000;
            x_o  <= 8'h00;
            a_o  <= 8'h00;
            cc_o <= 8'h00;
        end else begin
            vec_load_o <= 1'b0;
            restore_o  <= 1'b0;
            irq_ack_o  <= {NV{1'b0}};
            case (state_r)
                // Reset skips stacking and fetches from the reset vector
                S_RSTV: begin
                    vec_addr_o <= `NPIU_VEC_RESET;
                    vec_load_o <= 1'b1;
                    state_r    <= S_IDLE;
                end
                S_IDLE: begin
                    if (return_from_handler_i) begin
                        state_r <= S_POPA;
                        cnt_r   <= 3'h0;
                    end else if (take) begin
                        // Non-maskable beat all maskable and ignore level
                        if (tli_pend_r) begin
                            sel_vec_r  <= `NPIU_VEC_TOP;
                            sel_code_r <= `NPIU_CODE_L3;
                            sel_ack_r  <= {NV{1'b0}};
                        end else if (trap_pend_r) begin
                            sel_vec_r  <= `NPIU_VEC_TRAP;
                            sel_code_r <= `NPIU_CODE_L3;
                            sel_ack_r  <= {NV{1'b0}};
                        end else begin
                            sel_vec_r  <= VEC_TOP - {11'h000, win_idx, 1'b0};
                            sel_code_r <= win_code;
                            sel_ack_r  <= sel_onehot(win_idx);
                        end
                        cc_push_r <= cc_i;
                        cc_push_r[`NPIU_CC_BIT_HI] <= cur_code_r[1];
                        cc_push_r[`NPIU_CC_BIT_LO] <= cur_code_r[0];
                        ram_wdata_o <= pc_i[7:0];
                        halt_r  <= 1'b0;
                        wait_r  <= 1'b0;
                        cnt_r   <= 3'h0;
                        state_r <= S_PUSH;
                    end else if (cc_pop_i) begin
                        cur_code_r <= {cc_pop_data_i[`NPIU_CC_BIT_HI],
                                       cc_pop_data_i[`NPIU_CC_BIT_LO]};
                    end else if (mask_all_instr_i) begin
                        cur_code_r <= `NPIU_CODE_L3;
                    end else if (unmask_instr_i) begin
                        cur_code_r <= `NPIU_CODE_L0;
                    end else if (halt_instr_i) begin
                        cur_code_r <= `NPIU_CODE_L0;
                        halt_r     <= 1'b1;
                    end else if (wait_for_irq_instr_i) begin
                        cur_code_r <= `NPIU_CODE_L0;
                        wait_r     <= 1'b1;
                    end
                end
                // One byte per cycle, data staged one cycle ahead
                S_PUSH: begin
                    case (cnt_r)
                        3'h0:    ram_wdata_o <= pc_i[15:8];
                        3'h1:    ram_wdata_o <= x_i;
                        3'h2:    ram_wdata_o <= a_i;
                        3'h3:    ram_wdata_o <= cc_push_r;
                        default: ram_wdata_o <= 8'h00;
                    endcase
                    cnt_r <= cnt_r + 3'h1;
                    if (cnt_r == `NPIU_INT_FRAME - 3'h1) begin
                        state_r <= S_VEC;
                    end
                end
                // Level set from the vector's field in the same cycle as the vector load
                S_VEC: begin
                    cur_code_r <= sel_code_r;
                    vec_addr_o <= sel_vec_r;
                    vec_load_o <= 1'b1;
                    irq_ack_o  <= sel_ack_r;
                    state_r    <= S_IDLE;
                end
                S_POPA: begin
                    state_r <= S_POPD;
                end
                // Capture popped byte: flags, A, X, PCH, PC_LOW_BYTE
                S_POPD: begin
                    case (cnt_r)
                        3'h0: begin
                            cc_o       <= ram_rdata_i;
                            cur_code_r <= {ram_rdata_i[`NPIU_CC_BIT_HI],
                                           ram_rdata_i[`NPIU_CC_BIT_LO]};
                        end
                        3'h1:    a_o <= ram_rdata_i;
                        3'h2:    x_o <= ram_rdata_i;
                        3'h3:    pc_o[15:8] <= ram_rdata_i;
                        default: pc_o[7:0]  <= ram_rdata_i;
                    endcase
                    cnt_r <= cnt_r + 3'h1;
                    if (cnt_r == `NPIU_INT_FRAME - 3'h1) begin
                        restore_o <= 1'b1;
                        state_r   <= S_IDLE;
                    end else begin
                        state_r <= S_POPA;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // npiu_core

`default_nettype wire

// [test/npiu_core_sva.sv]
// Checker for the nested priority interrupt unit, bound to npiu_core.
// Assumes one clock domain and the core's own port names.
`timescale 1ns/100ps
`default_nettype none
module npiu_core_sva #(
    parameter NV = 14
) (
    input wire logic          clock_i,
    input wire logic          rst_b_i,
    input wire logic          ram_we_o,
    input wire logic [15:0]   ram_addr_o,
    input wire logic [15:0]   stack_ptr_o,
    input wire logic [1:0]    flags_prio_o,
    input wire logic          vec_load_o,
    input wire logic [15:0]   vec_addr_o,
    input wire logic [NV-1:0] irq_ack_o,
    input wire logic          restore_o,
    input wire logic [7:0]    cc_o,
    input wire logic          halted_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    // Reset state and the reset vector fetch
    a_reset_values: assert property ($rose(rst_b_i) |-> stack_ptr_o == 16'h017F && flags_prio_o == 2'h3)
        else $error("bad state out of reset");
    a_reset_vector: assert property ($rose(rst_b_i) |-> ##[1:3] vec_load_o && vec_addr_o == 16'hFFFE)
        else $error("reset vector not fetched");
    // Upper nine bits never move, so wrap stays inside the stack page
    a_sp_upper_fixed: assert property (stack_ptr_o[15:7] == 9'h002)
        else $error("stack pointer upper bits moved");
    // Context frame: five writes, then the vector load
    a_push_run: assert property ($rose(ram_we_o) |-> ram_we_o [*5] ##1 !ram_we_o ##1 vec_load_o)
        else $error("context frame not five bytes");
    a_push_at_sp: assert property (ram_we_o |-> ram_addr_o == stack_ptr_o)
        else $error("push not at stack pointer");
    a_push_order: assert property (ram_we_o && $past(ram_we_o) |-> ram_addr_o[6:0] == $past(ram_addr_o[6:0]) - 7'h01)
        else $error("push addresses not descending");
    a_sp_after_entry: assert property ($fell(ram_we_o) |-> ##1 stack_ptr_o[6:0] == $past(ram_addr_o[6:0], 6) - 7'h05)
        else $error("stack pointer not five lower");
    a_nmi_level: assert property (vec_load_o && irq_ack_o == '0 |-> flags_prio_o == 2'h3)
        else $error("non-maskable entry not at level 3");
    a_ack_onehot: assert property (irq_ack_o != '0 |-> vec_load_o && $onehot(irq_ack_o))
        else $error("acknowledge without single vector load");
    a_vec_range: assert property (vec_load_o |-> vec_addr_o >= 16'hFFE0 && !vec_addr_o[0])
        else $error("vector outside the table");
    a_restore_level: assert property (restore_o |-> flags_prio_o == {cc_o[5], cc_o[3]})
        else $error("level not restored from popped flags");

    c_maskable: cover property (vec_load_o && irq_ack_o != '0);
    c_return: cover property (restore_o);
    c_trap: cover property (vec_load_o && vec_addr_o == 16'hFFFC);
    c_wake: cover property ($fell(halted_o));
endmodule // npiu_core_sva

bind npiu_core npiu_core_sva #(.NV(NV)) u_sva (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o), .stack_ptr_o(stack_ptr_o),
    .flags_prio_o(flags_prio_o), .vec_load_o(vec_load_o), .vec_addr_o(vec_addr_o),
    .irq_ack_o(irq_ack_o), .restore_o(restore_o), .cc_o(cc_o), .halted_o(halted_o));
`default_nettype wire

// [test/npiu_stack_ram.sv]
// Stack RAM partner: 256 bytes, read data one cycle after the address.
// Assumes the core writes only during its push cycles.
`timescale 1ns/100ps
`default_nettype none
module npiu_stack_ram (
    input  wire logic        clock_i,
    input  wire logic [15:0] ram_addr_i,
    input  wire logic [7:0]  ram_wdata_i,
    input  wire logic        ram_we_i,
    output var  logic [7:0]  ram_rdata_o
);
    logic [7:0] mem [0:255];
    // Registered read; unwritten bytes read as unknown, so stale data shows
    always @(posedge clock_i) begin
        if (ram_we_i) mem[ram_addr_i[7:0]] <= ram_wdata_i;
        ram_rdata_o <= mem[ram_addr_i[7:0]];
    end
endmodule // npiu_stack_ram
`default_nettype wire

// [test/tb.sv]
// Testbench of npiu_core: CPU side driven by tasks, stack RAM by a model.
// Inputs change 1 ns after the rising edge.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clock_i, rst_b_i, instr_end_i, unmask_instr_i, mask_all_instr_i, halt_instr_i;
    logic return_from_handler_i, wait_for_irq_instr_i, cc_pop_i, trap_instr_i, prio_wr_i;
    logic stack_reinit_instr_i, sp_load_i, cpu_push_i, cpu_pop_i, top_pin_irq_i, ram_we_o;
    logic vec_load_o, restore_o, busy_o, halted_o;
    logic [1:0]  prio_addr_i, flags_prio_o;
    logic [7:0]  cc_pop_data_i, sp_load_data_i, x_i, a_i, cc_i, prio_wdata_i, prio_rdata_o;
    logic [7:0]  ram_rdata_i, ram_wdata_o, x_o, a_o, cc_o;
    logic [13:0] irq_req_i, irq_en_i, irq_ack_o;
    logic [15:0] pc_i, ram_addr_o, stack_ptr_o, vec_addr_o, pc_o;
    logic [7:0]  frame [5] = '{8'h34, 8'h12, 8'h56, 8'h78, 8'hE2};
    int          n_fail = 0;
    int          num_checks = 0;

    npiu_core DUT (.*);
    npiu_stack_ram u_ram (.clock_i(clock_i), .ram_addr_i(ram_addr_o),
        .ram_wdata_i(ram_wdata_o), .ram_we_i(ram_we_o), .ram_rdata_o(ram_rdata_i));

    // 50 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle request on a CPU strobe
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask

    task automatic wr_prio(input logic [1:0] a, input logic [7:0] d);
        prio_addr_i = a;
        prio_wdata_i = d;
        pulse(prio_wr_i);
        // Idle edge, so back-to-back writes never set the strobe twice at once
        tick(1);
    endtask

    task automatic rd_prio(input logic [1:0] a, input logic [7:0] e);
        prio_addr_i = a;
        tick(1);
        chk(prio_rdata_o, e);
    endtask

    // Bounded wait, so a lost entry ends as a mismatch, not a hang
    task automatic wait_vec(input logic [15:0] va, input logic [1:0] lv, input logic [13:0] ack);
        for (int i = 0; i < 60 && vec_load_o !== 1'b1; i++) tick(1);
        chk(vec_load_o, 1'b1);
        chk(vec_addr_o, va);
        chk(flags_prio_o, lv);
        chk(irq_ack_o, ack);
        tick(1);
    endtask

    task automatic test_done;
        if (n_fail == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clock_i);
        n_fail++;
        test_done;
    end

    initial begin
        {instr_end_i, unmask_instr_i, mask_all_instr_i, halt_instr_i, return_from_handler_i} = '0;
        {wait_for_irq_instr_i, cc_pop_i, trap_instr_i, prio_wr_i, stack_reinit_instr_i} = '0;
        {sp_load_i, cpu_push_i, cpu_pop_i, top_pin_irq_i, prio_addr_i, irq_req_i} = '0;
        {cc_pop_data_i, sp_load_data_i, prio_wdata_i} = '0;
        pc_i = 16'h1234;
        x_i = 8'h56;
        a_i = 8'h78;
        cc_i = 8'hE2;
        irq_en_i = 14'h0006;
        rst_b_i = 1'b0;
        tick(16);
        rst_b_i = 1'b1;
        chk(stack_ptr_o, 16'h017F);
        chk(flags_prio_o, 2'h3);
        wait_vec(16'hFFFE, 2'h3, 14'h0000);
        // Mask, pop, wait and unmask set the level
        pulse(mask_all_instr_i);
        chk(flags_prio_o, 2'h3);
        cc_pop_data_i = 8'h08;
        pulse(cc_pop_i);
        chk(flags_prio_o, 2'h1);
        pulse(wait_for_irq_instr_i);
        chk(flags_prio_o, 2'h2);
        pulse(mask_all_instr_i);
        pulse(unmask_instr_i);
        chk(flags_prio_o, 2'h2);
        // Level-0 fields keep their old value; top nibble of bank 3 fixed
        wr_prio(2'h0, 8'hCF);
        wr_prio(2'h0, 8'h64);
        rd_prio(2'h0, 8'h44);
        wr_prio(2'h3, 8'h00);
        rd_prio(2'h3, 8'hF0);
        // Vector 1 at level 1 and vector 2 at level 2 together
        irq_req_i = 14'h0006;
        tick(1);
        irq_req_i = '0;
        pulse(instr_end_i);
        wait_vec(16'hFFF6, 2'h0, 14'h0004);
        for (int i = 0; i < 5; i++) chk(u_ram.mem[8'h7F - i], frame[i]);
        chk(stack_ptr_o, 16'h017A);
        pulse(instr_end_i);
        tick(2);
        chk(busy_o, 1'b0);
        pulse(return_from_handler_i);
        for (int i = 0; i < 30 && restore_o !== 1'b1; i++) tick(1);
        chk(restore_o, 1'b1);
        chk(pc_o, 16'h1234);
        chk({x_o, a_o}, 16'h5678);
        chk(cc_o, 8'hE2);
        chk(flags_prio_o, 2'h2);
        tick(1);
        chk(stack_ptr_o, 16'h017F);
        // Latched vector 1 now outranks level 0
        pulse(instr_end_i);
        wait_vec(16'hFFF8, 2'h1, 14'h0002);
        // Trap at level 3
        pulse(mask_all_instr_i);
        pulse(trap_instr_i);
        pulse(instr_end_i);
        wait_vec(16'hFFFC, 2'h3, 14'h0000);
        chk(stack_ptr_o, 16'h0175);
        // Halt, then the top pin wakes it
        pulse(halt_instr_i);
        chk(halted_o, 1'b1);
        chk(flags_prio_o, 2'h2);
        top_pin_irq_i = 1'b1;
        wait_vec(16'hFFFA, 2'h3, 14'h0000);
        chk(halted_o, 1'b0);
        top_pin_irq_i = 1'b0;
        // Wrap both ways at the page ends
        sp_load_data_i = 8'h00;
        pulse(sp_load_i);
        chk(stack_ptr_o, 16'h0100);
        pulse(cpu_push_i);
        chk(stack_ptr_o, 16'h017F);
        pulse(cpu_pop_i);
        chk(stack_ptr_o, 16'h0100);
        pulse(stack_reinit_instr_i);
        chk(stack_ptr_o, 16'h017F);
        // Equal levels: vector 1 has the higher hardware priority
        wr_prio(2'h0, 8'h54);
        pulse(unmask_instr_i);
        irq_req_i = 14'h0006;
        tick(1);
        irq_req_i = '0;
        pulse(instr_end_i);
        wait_vec(16'hFFF8, 2'h1, 14'h0002);
        test_done;
    end
endmodule // tb
`default_nettype wire
